/* rtl/usbsie_consts.svh */
/*
  Constants of the USB error, control, frame and token register slice:
  byte offsets, field positions, reset values and timing figures.
  Assumes inclusion by bare name from the frame timer and register slice modules.
*/
`ifndef USBSIE_CONSTS_SVH
`define USBSIE_CONSTS_SVH

// Register byte offsets on the APB slave.
`define USBSIE_OFF_ERR_IE     12'h000
`define USBSIE_OFF_CONTROL    12'h004
`define USBSIE_OFF_FRAME_HI   12'h008
`define USBSIE_OFF_TOKEN      12'h00C
`define USBSIE_OFF_ERR_FLAG   12'h010
`define USBSIE_OFF_GEN_IE     12'h014
`define USBSIE_OFF_GEN_FLAG   12'h018

// Error enable and error flag positions, shared layout.
`define USBSIE_ERR_STUFF      7
`define USBSIE_ERR_MATRIX     6
`define USBSIE_ERR_ENGINE     5
`define USBSIE_ERR_TURNAROUND 4
`define USBSIE_ERR_FIELD_SIZE 3
`define USBSIE_ERR_DATA_CRC   2
`define USBSIE_ERR_TOKEN_EOF  1
`define USBSIE_ERR_PACKET_ID  0

// Control register positions.
`define USBSIE_CTL_ENABLE     0
`define USBSIE_CTL_PINGPONG   1
`define USBSIE_CTL_RESUME     2
`define USBSIE_CTL_HOST_CTL   3
`define USBSIE_CTL_TOK_BUSY   5

// General interrupt enable and flag positions.
`define USBSIE_GEN_TOK_DONE   0
`define USBSIE_GEN_ERROR      1
`define USBSIE_GEN_SOF_SENT   2

// Token register fields.
`define USBSIE_TOK_PID_HI     7
`define USBSIE_TOK_PID_LO     4
`define USBSIE_TOK_EP_HI      3
`define USBSIE_TOK_EP_LO      0

// Reset values.
`define USBSIE_RST_BYTE       8'h00
`define USBSIE_RST_WORD       32'h0000_0000

// Frame timing: one start-of-frame token per millisecond at a 100 ns clock.
`define USBSIE_FRAME_US       1000
`define USBSIE_CLK_PERIOD_NS  100
`define USBSIE_SOF_CYCLES     ((`USBSIE_FRAME_US * 1000) / `USBSIE_CLK_PERIOD_NS)

`endif

/* rtl/usbsie_pkg.sv */
/*
  Types of the USB error, control, frame and token register slice.
  Assumes the constants header sits on the include path.
*/
package usbsie_pkg;

  // Register selected by an APB address.
  typedef enum logic [2:0] {
    USBSIE_REG_ERR_IE   = 3'h0,
    USBSIE_REG_CONTROL  = 3'h1,
    USBSIE_REG_FRAME_HI = 3'h2,
    USBSIE_REG_TOKEN    = 3'h3,
    USBSIE_REG_ERR_FLAG = 3'h4,
    USBSIE_REG_GEN_IE   = 3'h5,
    USBSIE_REG_GEN_FLAG = 3'h6,
    USBSIE_REG_NONE     = 3'h7
  } usbsie_reg_t;

  // A token command as handed to the bus engine.
  typedef struct packed {
    logic [3:0] pid;
    logic [3:0] endpoint;
  } usbsie_tok_cmd_t;

  // Whole state of the register slice.
  typedef struct packed {
    logic [7:0]      err_ie;
    logic [7:0]      err_flag;
    logic            module_en;
    logic            pingpong_rst;
    logic            resume;
    logic            host_ctl;
    logic            tok_busy;
    logic [2:0]      frame_upper;
    usbsie_tok_cmd_t tok;
    logic [2:0]      gen_ie;
    logic            tok_done_flag;
    logic            sof_sent_flag;
    logic [31:0]     rdata;
    logic            tok_start;
    logic            host_rst;
    logic            eop_start;
    logic            irq;
  } usbsie_state_t;

  // State of the frame timer.
  typedef struct packed {
    logic [15:0] count;
    logic        tick;
  } usbsie_tick_state_t;

endpackage

/* rtl/usbsie_frame_timer.sv */
/*
  Frame timer: a free counter that gives a one-cycle tick every frame period.
  Assumes the same clock and reset as the register slice that instantiates it.
*/
`include "usbsie_consts.svh"

module usbsie_frame_timer
  import usbsie_pkg::*;
#(
  parameter int unsigned CYCLES = `USBSIE_SOF_CYCLES
)
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic enable,
  output logic      tick
);

  localparam logic [15:0] LAST = 16'(CYCLES - 1);

  usbsie_tick_state_t s_q;
  usbsie_tick_state_t s_d;

  // Count while enabled; restart from zero whenever disabled so the first frame is full length.
  always_comb
  begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (!enable)
    begin
      s_d.count = 16'h0000;
    end
    else if (s_q.count == LAST)
    begin
      s_d.count = 16'h0000;
      s_d.tick  = 1'b1;
    end
    else
    begin
      s_d.count = s_q.count + 16'h0001;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule

/* rtl/usbsie_regs.sv */
/*
  USB error interrupt enables, control bits, upper frame number and token
  command register, reached as an APB slave with zero wait states.
  Assumes the USB bus engine sits on the same clock and drives the error
  events, token completion and received start-of-frame pulses directly.
*/
`include "usbsie_consts.svh"

// Summary of operation
// [R1] Error enable bits 7..4 unmask stuff, matrix, engine, turnaround flags; reset zero.
// [R2] Enable bit 3 unmasks field size error, bit 2 unmasks data CRC failure.
// [R3] Enable bit 1 unmasks token CRC error in device role, frame end in host.
// [R4] Enable bit 0 unmasks the packet identifier check failure flag.
// [R5] Enabled errors reach the module interrupt only with general enable bit 1 set.
// [R6] Error enable bits 31..8 always read as zero.
// [R7] Ping-pong reset bit forces all buffer pointers to the even banks.
// [R8] In device role control bit 0 enables the module and its circuitry.
// [R9] In host role with frame start enabled, one start token per millisecond.
// [R10] Toggling the host control bit resets all host control logic.
// [R11] Software holds resume 10 ms as function, 25 ms as host, then clears.
// [R12] In host role clearing resume appends a low-speed end of packet.
// [R13] Software checks token busy before writing a new token command.
// [R14] Upper frame number bits 2..0 update on every received start token.
// [R15] Token type field is written only as SETUP, IN or OUT codes.
// [R16] Token bits 3..0 carry a valid target endpoint number.
// [R17] In host role a token write starts one transaction; busy until it ends.
// [R18] Error request stays high while any flag and its enable are both set.
module usbsie_regs
  import usbsie_pkg::*;
#(
  parameter int unsigned SOF_CYCLES = `USBSIE_SOF_CYCLES
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        host_mode,
  input  wire logic [7:0]  err_event,
  input  wire logic        sof_received,
  input  wire logic [2:0]  sof_frame_upper,
  input  wire logic        tok_done,
  output logic             module_enable,
  output logic             pingpong_reset,
  output logic             resume_drive,
  output logic             resume_eop_start,
  output logic             host_logic_reset,
  output logic             sof_token_start,
  output logic             tok_start,
  output usbsie_tok_cmd_t  tok_cmd,
  output logic             error_irq,
  output logic             module_irq_flag
);

  usbsie_state_t s_q;
  usbsie_state_t s_d;
  usbsie_reg_t   sel;
  logic          wr_en;
  logic          rd_setup;
  logic          sof_tick;
  logic          sof_enabled;
  logic          err_pending_d;

  // Address decode, shared by the read path, the write path and the error answer.
  function automatic usbsie_reg_t decode(input logic [11:0] addr);
    case (addr)
      `USBSIE_OFF_ERR_IE:   decode = USBSIE_REG_ERR_IE;
      `USBSIE_OFF_CONTROL:  decode = USBSIE_REG_CONTROL;
      `USBSIE_OFF_FRAME_HI: decode = USBSIE_REG_FRAME_HI;
      `USBSIE_OFF_TOKEN:    decode = USBSIE_REG_TOKEN;
      `USBSIE_OFF_ERR_FLAG: decode = USBSIE_REG_ERR_FLAG;
      `USBSIE_OFF_GEN_IE:   decode = USBSIE_REG_GEN_IE;
      `USBSIE_OFF_GEN_FLAG: decode = USBSIE_REG_GEN_FLAG;
      default:              decode = USBSIE_REG_NONE;
    endcase
  endfunction

  // Any error flag whose enable is set, used for both the live status and the request.
  function automatic logic err_active(input logic [7:0] flags, input logic [7:0] enables);
    err_active = |(flags & enables); // [R1] [R2] [R3] [R4] [R18]
  endfunction

  // Bus qualifiers. Reads are captured in setup so prdata comes from a flop in the access phase.
  assign sel      = decode(paddr);
  assign wr_en    = psel && penable && pwrite && (sel != USBSIE_REG_NONE);
  assign rd_setup = psel && !penable && !pwrite;

  // Frame start tokens run only in host role with the frame start enable set.
  assign sof_enabled = host_mode && s_q.module_en; // [R9]

  // Millisecond frame timer.
  usbsie_frame_timer #(
    .CYCLES (SOF_CYCLES)
  ) u_frame_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (sof_enabled),
    .tick    (sof_tick)
  );

  // Next-state logic for every register and pulse of the slice.
  always_comb
  begin
    s_d           = s_q;
    s_d.tok_start = 1'b0;
    s_d.host_rst  = 1'b0;
    s_d.eop_start = 1'b0;

    // Software writes; set-by-hardware flags are handled after, so an event wins a clear.
    if (wr_en)
    begin
      case (sel)
        USBSIE_REG_ERR_IE:
        begin
          s_d.err_ie = pwdata[7:0]; // [R1] [R2] [R3] [R4]
        end
        USBSIE_REG_CONTROL:
        begin
          s_d.module_en    = pwdata[`USBSIE_CTL_ENABLE]; // [R8] [R9]
          s_d.pingpong_rst = pwdata[`USBSIE_CTL_PINGPONG]; // [R7]
          s_d.resume       = pwdata[`USBSIE_CTL_RESUME];
          s_d.host_ctl     = pwdata[`USBSIE_CTL_HOST_CTL];
          // Any change of the host control bit, either way, is a host logic reset.
          s_d.host_rst     = (pwdata[`USBSIE_CTL_HOST_CTL] != s_q.host_ctl); // [R10]
          // A falling resume in host role closes the resume signalling with an end of packet.
          s_d.eop_start    = host_mode && s_q.resume && !pwdata[`USBSIE_CTL_RESUME]; // [R12]
        end
        USBSIE_REG_TOKEN:
        begin
          s_d.tok.pid      = pwdata[`USBSIE_TOK_PID_HI:`USBSIE_TOK_PID_LO];
          s_d.tok.endpoint = pwdata[`USBSIE_TOK_EP_HI:`USBSIE_TOK_EP_LO];
          // Only the host issues tokens; reserved codes are not filtered, the engine sees them as written.
          if (host_mode)
          begin
            s_d.tok_start = 1'b1; // [R17]
          end
        end
        USBSIE_REG_ERR_FLAG:
        begin
          s_d.err_flag = s_q.err_flag & ~pwdata[7:0];
        end
        USBSIE_REG_GEN_IE:
        begin
          s_d.gen_ie = pwdata[2:0]; // [R5]
        end
        USBSIE_REG_GEN_FLAG:
        begin
          if (pwdata[`USBSIE_GEN_TOK_DONE])
          begin
            s_d.tok_done_flag = 1'b0;
          end
          if (pwdata[`USBSIE_GEN_SOF_SENT])
          begin
            s_d.sof_sent_flag = 1'b0;
          end
        end
        default:
        begin
          s_d.rdata = s_q.rdata;
        end
      endcase
    end

    // Error events from the bus engine set sticky flags over any clear in the same cycle.
    s_d.err_flag = s_d.err_flag | err_event;

    // Token busy: completion drops it, a new host token raises it, and the raise wins.
    if (tok_done && s_q.tok_busy)
    begin
      s_d.tok_busy      = 1'b0; // [R17]
      s_d.tok_done_flag = 1'b1;
    end
    if (s_d.tok_start)
    begin
      s_d.tok_busy = 1'b1; // [R17] [R13]
    end

    // Each start token sent is reported as a sticky event.
    if (sof_tick)
    begin
      s_d.sof_sent_flag = 1'b1;
    end

    // Upper frame number follows every received start token.
    if (sof_received)
    begin
      s_d.frame_upper = sof_frame_upper; // [R14]
    end

    // Read capture in the setup phase; unimplemented bits read as zero.
    if (rd_setup)
    begin
      s_d.rdata = `USBSIE_RST_WORD;
      case (sel)
        USBSIE_REG_ERR_IE:
        begin
          s_d.rdata[7:0] = s_q.err_ie; // [R6]
        end
        USBSIE_REG_CONTROL:
        begin
          s_d.rdata[`USBSIE_CTL_ENABLE]   = s_q.module_en;
          s_d.rdata[`USBSIE_CTL_PINGPONG] = s_q.pingpong_rst;
          s_d.rdata[`USBSIE_CTL_RESUME]   = s_q.resume;
          s_d.rdata[`USBSIE_CTL_HOST_CTL] = s_q.host_ctl;
          s_d.rdata[`USBSIE_CTL_TOK_BUSY] = s_q.tok_busy; // [R13]
        end
        USBSIE_REG_FRAME_HI:
        begin
          s_d.rdata[2:0] = s_q.frame_upper; // [R14]
        end
        USBSIE_REG_TOKEN:
        begin
          s_d.rdata[7:0] = s_q.tok;
        end
        USBSIE_REG_ERR_FLAG:
        begin
          s_d.rdata[7:0] = s_q.err_flag;
        end
        USBSIE_REG_GEN_IE:
        begin
          s_d.rdata[2:0] = s_q.gen_ie;
        end
        USBSIE_REG_GEN_FLAG:
        begin
          s_d.rdata[`USBSIE_GEN_TOK_DONE] = s_q.tok_done_flag;
          s_d.rdata[`USBSIE_GEN_ERROR]    = err_active(s_q.err_flag, s_q.err_ie);
          s_d.rdata[`USBSIE_GEN_SOF_SENT] = s_q.sof_sent_flag;
        end
        default:
        begin
          s_d.rdata = `USBSIE_RST_WORD;
        end
      endcase
    end

    // Module interrupt from the next state, so it tracks flags without an extra cycle of lag.
    err_pending_d = err_active(s_d.err_flag, s_d.err_ie); // [R18]
    s_d.irq = (err_pending_d && s_d.gen_ie[`USBSIE_GEN_ERROR]) || // [R5]
              (s_d.tok_done_flag && s_d.gen_ie[`USBSIE_GEN_TOK_DONE]) ||
              (s_d.sof_sent_flag && s_d.gen_ie[`USBSIE_GEN_SOF_SENT]);
  end

  // State register; every field clears at reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Bus answers: no wait states, an unmapped address answers with an error.
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (sel == USBSIE_REG_NONE);
  assign prdata  = s_q.rdata;

  // Control outputs to the bus engine.
  assign module_enable    = s_q.module_en && !host_mode; // [R8]
  assign pingpong_reset   = s_q.pingpong_rst; // [R7]
  // Resume is driven as written; its length is timed by software.
  assign resume_drive     = s_q.resume; // [R11]
  assign resume_eop_start = s_q.eop_start; // [R12]
  assign host_logic_reset = s_q.host_rst; // [R10]
  assign sof_token_start  = sof_tick; // [R9]
  assign tok_start        = s_q.tok_start; // [R17]
  assign tok_cmd          = s_q.tok; // [R15] [R16]
  assign error_irq        = err_active(s_q.err_flag, s_q.err_ie); // [R18]
  assign module_irq_flag  = s_q.irq;

endmodule

/* test/usbsie_engine_model.sv */
/*
  Bus engine model: ends each started token after a delay the bench sets.
  Assumes the clock and reset of the register slice.
*/
module usbsie_engine_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tok_start,
  input  wire logic [3:0] delay,
  output logic            tok_done
);
  logic [4:0] left_q;

  // Count the transaction down and pulse done once, so a slow bus shows.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      left_q   <= 5'h00;
      tok_done <= 1'b0;
    end
    else
    begin
      tok_done <= (left_q == 5'h01);
      if (tok_start)
        left_q <= {1'b0, delay} + 5'h01;
      else if (left_q != 5'h00)
        left_q <= left_q - 5'h01;
    end
  end
endmodule

/* test/usbsie_regs_sva.sv */
/*
  Port checker of the USB register slice.
  Assumes a bind into usbsie_regs and one clock domain.
*/
module usbsie_regs_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        host_mode,
  input wire logic [7:0]  err_event,
  input wire logic        module_enable,
  input wire logic        pingpong_reset,
  input wire logic        resume_drive,
  input wire logic        resume_eop_start,
  input wire logic        host_logic_reset,
  input wire logic        sof_token_start,
  input wire logic        tok_start,
  input wire logic        error_irq
);
  // Completed writes; pulses may land one or two edges later.
  wire wr     = psel && penable && pwrite;
  wire wr_ctl = wr && paddr == 12'h004;
  wire wr_tok = wr && paddr == 12'h00C;
  wire wr_irq = wr && (paddr == 12'h000 || paddr == 12'h010);
  wire eop_c  = wr_ctl && !pwdata[2] && resume_drive && host_mode;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_dev; $past(wr_ctl) |-> module_enable == (!host_mode && $past(pwdata[0])); endproperty
  a_dev: assert property (p_dev) else $error("module enable not as written");
  property p_pp; $changed(pingpong_reset) |-> $past(wr_ctl) && pingpong_reset == $past(pwdata[1]); endproperty
  a_pp: assert property (p_pp) else $error("pointer reset without write");
  property p_hr; host_logic_reset |-> $past(wr_ctl) || $past(wr_ctl, 2); endproperty
  a_hr: assert property (p_hr) else $error("stray host reset");
  property p_eop; eop_c |=> ##[0:1] resume_eop_start; endproperty
  a_eop: assert property (p_eop) else $error("no end of packet");
  property p_tok; wr_tok && host_mode |=> tok_start; endproperty
  a_tok: assert property (p_tok) else $error("token not started");
  property p_tokc; tok_start |-> $past(wr_tok && host_mode); endproperty
  a_tokc: assert property (p_tokc) else $error("stray token start");
  property p_sof; sof_token_start |-> $past(host_mode); endproperty
  a_sof: assert property (p_sof) else $error("frame start in device role");
  property p_rsv; psel && penable && !pwrite && paddr == 12'h000 |-> prdata[31:8] == 24'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("upper enable bits not zero");
  property p_ifall; $fell(error_irq) |-> $past(wr_irq); endproperty
  a_ifall: assert property (p_ifall) else $error("error request dropped");
  property p_irise; $rose(error_irq) |-> $past(|err_event) || $past(wr_irq); endproperty
  a_irise: assert property (p_irise) else $error("error request without cause");

  c_tok: cover property (tok_start);
  c_eop: cover property (resume_eop_start);
  c_sof: cover property (sof_token_start);
endmodule

bind usbsie_regs usbsie_regs_sva usbsie_regs_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .host_mode(host_mode), .err_event(err_event), .module_enable(module_enable),
  .pingpong_reset(pingpong_reset), .resume_drive(resume_drive), .resume_eop_start(resume_eop_start),
  .host_logic_reset(host_logic_reset), .sof_token_start(sof_token_start), .tok_start(tok_start),
  .error_irq(error_irq));

/* test/usbsie_regs_tb_top.sv */
/*
  Self-checking bench of the USB register slice over APB.
  Assumes the engine model and the checker are compiled beforehand.
*/
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("Error at %0t: got %0h expected %0h", $time, a, b); end end

module usbsie_regs_tb_top
  import usbsie_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SOF_N = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv_q;
  logic host_mode, sof_received, tok_done, module_enable, pingpong_reset, resume_drive;
  logic resume_eop_start, host_logic_reset, sof_token_start, tok_start, error_irq, module_irq_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [7:0] err_event;
  logic [2:0] sof_frame_upper;
  logic [3:0] delay;
  usbsie_tok_cmd_t tok_cmd;
  int failures, checks_done, n_hr, n_eop, n_tok, n_sof, cyc_n, sof_last, sof_gap;

  // Clock of 100 ns.
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  usbsie_regs #(.SOF_CYCLES(SOF_N)) usbsie_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .host_mode(host_mode), .err_event(err_event), .sof_received(sof_received),
    .sof_frame_upper(sof_frame_upper), .tok_done(tok_done), .module_enable(module_enable),
    .pingpong_reset(pingpong_reset), .resume_drive(resume_drive), .resume_eop_start(resume_eop_start),
    .host_logic_reset(host_logic_reset), .sof_token_start(sof_token_start), .tok_start(tok_start),
    .tok_cmd(tok_cmd), .error_irq(error_irq), .module_irq_flag(module_irq_flag));
  usbsie_engine_model usbsie_engine_model_inst (.pclk(pclk), .presetn(presetn), .tok_start(tok_start),
    .delay(delay), .tok_done(tok_done));

  // Pulses are counted here, so their exact cycle need not be guessed.
  always @(posedge pclk)
  begin
    cyc_n++;
    if (host_logic_reset === 1'b1) n_hr++;
    if (resume_eop_start === 1'b1) n_eop++;
    if (tok_start === 1'b1) n_tok++;
    if (sof_token_start === 1'b1)
    begin
      sof_gap = cyc_n - sof_last;
      sof_last = cyc_n;
      n_sof++;
    end
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer after an idle cycle; waits for pready under a bound.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      failures++;
      end_of_test;
    end
    rd_q = prdata;
    slv_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic fire(input logic [7:0] e);
    err_event <= e;
    @(posedge pclk);
    err_event <= 8'h00;
    cyc(3);
  endtask

  task automatic t_regs;
    for (int i = 0; i < 7; i++)
    begin
      xfer(1'b0, 12'(i * 4), 32'h0);
      `CHK(rd_q, 32'h0)
    end
    xfer(1'b1, 12'h000, 32'hFFFFFFFF);
    xfer(1'b0, 12'h000, 32'h0);
    `CHK(rd_q, 32'h000000FF)
    xfer(1'b1, 12'h008, 32'hFFFFFFFF);
    xfer(1'b0, 12'h008, 32'h0);
    `CHK(rd_q, 32'h0)
    xfer(1'b0, 12'h01C, 32'h0);
    `CHK(slv_q, 1'b1)
    `CHK(rd_q, 32'h0)
    $display("registers test done");
  endtask

  task automatic t_err;
    for (int i = 0; i < 8; i++)
    begin
      host_mode <= i[0];
      xfer(1'b1, 12'h014, 32'h2);
      xfer(1'b1, 12'h000, 32'(8'h01 << i));
      fire(8'h01 << ((i + 1) % 8));
      `CHK(error_irq, 1'b0)
      fire(8'h01 << i);
      `CHK(error_irq, 1'b1)
      `CHK(module_irq_flag, 1'b1)
      xfer(1'b1, 12'h014, 32'h0);
      cyc(2);
      `CHK(error_irq, 1'b1)
      `CHK(module_irq_flag, 1'b0)
      xfer(1'b1, 12'h010, 32'hFF);
      cyc(2);
      `CHK(error_irq, 1'b0)
    end
    $display("error test done");
  endtask

  task automatic t_ctl;
    int n;
    host_mode <= 1'b0;
    xfer(1'b1, 12'h004, 32'h1);
    cyc(2);
    `CHK(module_enable, 1'b1)
    host_mode <= 1'b1;
    cyc(2);
    `CHK(module_enable, 1'b0)
    xfer(1'b1, 12'h004, 32'h2);
    cyc(2);
    `CHK(pingpong_reset, 1'b1)
    n = n_hr;
    xfer(1'b1, 12'h004, 32'h8);
    xfer(1'b1, 12'h004, 32'h0);
    cyc(3);
    `CHK(pingpong_reset, 1'b0)
    `CHK(n_hr, n + 2)
    n = n_eop;
    xfer(1'b1, 12'h004, 32'h4);
    cyc(2);
    `CHK(resume_drive, 1'b1)
    // Short stand-in for the software hold; a real hold would outlast the run.
    cyc(10);
    xfer(1'b1, 12'h004, 32'h0);
    cyc(3);
    `CHK(resume_drive, 1'b0)
    `CHK(n_eop, n + 1)
    host_mode <= 1'b0;
    xfer(1'b1, 12'h004, 32'h4);
    xfer(1'b1, 12'h004, 32'h0);
    cyc(3);
    `CHK(n_eop, n + 1)
    $display("control test done");
  endtask

  task automatic t_tok;
    logic [3:0] pids [3] = '{4'hD, 4'h9, 4'h1};
    int t;
    int n;
    host_mode <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      delay <= 4'(k * 6);
      t = n_tok;
      xfer(1'b1, 12'h00C, {24'h0, pids[k], 4'(k + 2)});
      xfer(1'b0, 12'h004, 32'h0);
      `CHK(rd_q[5], 1'b1)
      n = 0;
      do
      begin
        xfer(1'b0, 12'h004, 32'h0);
        n++;
      end
      while (rd_q[5] !== 1'b0 && n < 20);
      `CHK(n < 20, 1'b1)
      `CHK(n_tok, t + 1)
      `CHK(tok_cmd, {pids[k], 4'(k + 2)})
    end
    host_mode <= 1'b0;
    t = n_tok;
    xfer(1'b1, 12'h00C, 32'h19);
    cyc(3);
    `CHK(n_tok, t)
    `CHK(tok_cmd, 8'h19)
    $display("token test done");
  endtask

  task automatic t_sof;
    int s;
    host_mode <= 1'b1;
    sof_frame_upper <= 3'h5;
    sof_received <= 1'b1;
    @(posedge pclk);
    sof_received <= 1'b0;
    xfer(1'b0, 12'h008, 32'h0);
    `CHK(rd_q, 32'h5)
    s = n_sof;
    xfer(1'b1, 12'h004, 32'h1);
    for (int i = 0; i < 100 && n_sof < s + 2; i++) @(posedge pclk);
    `CHK(n_sof >= s + 2, 1'b1)
    `CHK(sof_gap, SOF_N)
    // Token done is still sticky from the token test; frame sent is set by the ticks.
    xfer(1'b0, 12'h018, 32'h0);
    `CHK(rd_q, 32'h5)
    xfer(1'b1, 12'h004, 32'h0);
    cyc(2);
    s = n_sof;
    cyc(3 * SOF_N);
    `CHK(n_sof, s)
    xfer(1'b1, 12'h014, 32'h4);
    cyc(2);
    `CHK(module_irq_flag, 1'b1)
    xfer(1'b1, 12'h018, 32'h5);
    xfer(1'b0, 12'h018, 32'h0);
    `CHK(rd_q, 32'h0)
    `CHK(module_irq_flag, 1'b0)
    $display("frame test done");
  endtask

  // Main sequence.
  initial
  begin
    {presetn, psel, penable, pwrite, host_mode, sof_received} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    err_event = 8'h00;
    sof_frame_upper = 3'h0;
    delay = 4'h0;
    cyc(16);
    presetn <= 1'b1;
    t_regs;
    t_err;
    t_ctl;
    t_tok;
    t_sof;
    end_of_test;
  end
endmodule
